/* rtl/rgs_consts.vh */
// constants for the ramp units and step input block
// assumes a 50 MHz system clock and an apb bus with 32-bit data
`ifndef RGS_CONSTS_VH
`define RGS_CONSTS_VH

// register indices, byte address is four times the index
`define RGS_IDX_GCONF 10'h000
`define RGS_IDX_GEAR 10'h012
`define RGS_IDX_MAX_ACCEL 10'h040
`define RGS_IDX_MAX_DECEL 10'h041
`define RGS_IDX_START_ACCEL 10'h042
`define RGS_IDX_FINAL_DECEL 10'h043
`define RGS_IDX_STOP_DECEL 10'h044
`define RGS_IDX_JERK_1 10'h045
`define RGS_IDX_JERK_4 10'h048
`define RGS_IDX_PRESENT_ACCEL 10'h049
`define RGS_IDX_POSITION 10'h04a
`define RGS_IDX_RAMP_CTRL 10'h04b

// global_configuration fields
`define RGS_GC_RAW_ACCEL 1
`define RGS_GC_RAW_JERK 2
`define RGS_GC_SDIN_LO 6
`define RGS_GC_DIR_INV 8

// ramp_control fields
`define RGS_RC_RUN 0
`define RGS_RC_BRAKE 1

// reset values
`define RGS_GCONF_RST 32'h0000_0000
`define RGS_GEAR_RST 32'h0100_0000
`define RGS_PARAM_RST 24'h00_0000

// step input modes
`define RGS_SDIN_OFF 2'h0
`define RGS_SDIN_RISE 2'h1
`define RGS_SDIN_FALL 2'h2
`define RGS_SDIN_BOTH 2'h3

// clock and unit scaling, internal accel lsb is 2^-61 pulse/cycle^2
`define RGS_CLK_HZ 50000000
`define RGS_ACC_REAL_MUL 18'd236118
`define RGS_JERK_REAL_MUL 25'd20282410
`define RGS_ACC_OUT_MUL 12'd1137
`define RGS_MUL_SHIFT 10
`define RGS_OUT_SHIFT 20
`define RGS_ACC_RAW_SHIFT 24
`define RGS_JERK_RAW_SHIFT 8

// gearing accumulator, one whole step in 8.24 fixed point
`define RGS_GEAR_ONE 40'sh00_0100_0000

`endif

/* rtl/rgs_ramp_units.v */
// ramp unit conversion, jerk limited acceleration and step input gearing
// assumes an apb master on CLK_SYS and step pins from another controller
`timescale 1ns/1ps
module rgs_ramp_units (
  input wire CLK_SYS,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire STEP_IN,
  input wire DIR_IN,
  output reg INT_STEP,
  output reg INT_DIR,
  output reg INT_GEN_EN,
  output reg [31:0] PRESENT_ACCEL
);
`include "rgs_consts.vh"

  // ****************************************
  // helpers
  // ****************************************
  // slot of a ramp parameter, 4'hf when none
  function [3:0] param_slot;
    input [9:0] idx;
    reg [9:0] diff;
    begin
      diff = idx - `RGS_IDX_MAX_ACCEL;
      if (idx >= `RGS_IDX_MAX_ACCEL && idx <= `RGS_IDX_JERK_4)
        param_slot = diff[3:0];
      else
        param_slot = 4'hf;
    end
  endfunction

  // accel parameter to internal units
  function [47:0] acc_to_int;
    input [23:0] val;
    input raw;
    reg [41:0] prod;
    begin
      prod = val * `RGS_ACC_REAL_MUL;
      if (raw)
        acc_to_int = {val, 24'h00_0000};
      else
        acc_to_int = {16'h0000, prod[41:10]};
    end
  endfunction

  // jerk parameter to internal units per cycle
  function [47:0] jerk_to_int;
    input [23:0] val;
    input raw;
    reg [48:0] prod;
    begin
      prod = val * `RGS_JERK_REAL_MUL;
      if (raw)
        jerk_to_int = {16'h0000, val, 8'h00};
      else
        jerk_to_int = {39'h00_0000_0000, prod[48:40]};
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] gconf_reg;
  reg [31:0] gear_reg;
  reg [1:0] ramp_ctrl_reg;
  reg [23:0] param_reg [0:8];
  reg [31:0] position_reg;
  reg [31:0] prdata_reg;
  reg pslverr_reg;
  reg [31:0] rd_next;
  reg err_next;

  wire [9:0] idx = PADDR[11:2];
  wire [3:0] slot = param_slot(idx);
  wire wr_en = PSEL & PENABLE & PWRITE;
  wire raw_acc = gconf_reg[`RGS_GC_RAW_ACCEL];
  wire raw_jerk = gconf_reg[`RGS_GC_RAW_JERK];
  wire [1:0] sdin_mode = gconf_reg[`RGS_GC_SDIN_LO+1:`RGS_GC_SDIN_LO];
  wire dir_inv = gconf_reg[`RGS_GC_DIR_INV];

  assign PREADY = 1'b1;
  assign PRDATA = prdata_reg;
  assign PSLVERR = pslverr_reg & PSEL & PENABLE;

  // ****************************************
  // apb read mux, sampled in setup phase
  // ****************************************
  always @* begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    if (idx == `RGS_IDX_GCONF)
      rd_next = gconf_reg;
    else if (idx == `RGS_IDX_GEAR)
      rd_next = gear_reg;
    else if (slot != 4'hf)
      rd_next = {8'h00, param_reg[slot]};
    else if (idx == `RGS_IDX_PRESENT_ACCEL)
      rd_next = PRESENT_ACCEL;
    else if (idx == `RGS_IDX_POSITION)
      rd_next = position_reg;
    else if (idx == `RGS_IDX_RAMP_CTRL)
      rd_next = {30'h0000_0000, ramp_ctrl_reg};
    else
      err_next = 1'b1;
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      prdata_reg <= PWRITE ? 32'h0000_0000 : rd_next;
      pslverr_reg <= err_next;
    end
  end

  // ****************************************
  // apb writes
  // ****************************************
  integer i;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      gconf_reg <= `RGS_GCONF_RST;
      gear_reg <= `RGS_GEAR_RST;
      ramp_ctrl_reg <= 2'h0;
      for (i = 0; i < 9; i = i + 1)
        param_reg[i] <= `RGS_PARAM_RST;
    end else if (wr_en) begin
      if (idx == `RGS_IDX_GCONF)
        gconf_reg <= PWDATA;
      else if (idx == `RGS_IDX_GEAR)
        gear_reg <= PWDATA;
      else if (slot != 4'hf)
        param_reg[slot] <= PWDATA[23:0];
      else if (idx == `RGS_IDX_RAMP_CTRL)
        ramp_ctrl_reg <= PWDATA[1:0];
    end
  end

  // ****************************************
  // jerk limited acceleration follower
  // ****************************************
  reg signed [47:0] acc_reg;
  reg signed [47:0] acc_next;
  reg signed [47:0] target;
  reg signed [47:0] step_up;
  reg signed [47:0] step_dn;
  reg signed [59:0] out_prod;
  wire signed [47:0] max_accel_i = acc_to_int(param_reg[0], raw_acc);
  wire signed [47:0] max_decel_i = acc_to_int(param_reg[1], raw_acc);
  wire signed [47:0] jup_i = jerk_to_int(param_reg[5], raw_jerk);
  wire signed [47:0] jdn_i = jerk_to_int(param_reg[7], raw_jerk);

  always @* begin
    if (ramp_ctrl_reg[`RGS_RC_BRAKE])
      target = -max_decel_i;
    else if (ramp_ctrl_reg[`RGS_RC_RUN])
      target = max_accel_i;
    else
      target = 48'sh0000_0000_0000;
    step_up = acc_reg + jup_i;
    step_dn = acc_reg - jdn_i;
    if (acc_reg < target)
      acc_next = (step_up > target) ? target : step_up;
    else if (acc_reg > target)
      acc_next = (step_dn < target) ? target : step_dn;
    else
      acc_next = acc_reg;
    out_prod = acc_reg * $signed({1'b0, `RGS_ACC_OUT_MUL});
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      acc_reg <= 48'sh0000_0000_0000;
      PRESENT_ACCEL <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_next;
      PRESENT_ACCEL <= out_prod[51:20];
    end
  end

  // ****************************************
  // external step input and gearing
  // ****************************************
  wire ext_step;
  wire dir_lvl;

  rgs_step_sync u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .step_pin(STEP_IN),
    .dir_pin(DIR_IN),
    .mode(sdin_mode),
    .step_evt(ext_step),
    .dir_level(dir_lvl)
  );

  reg signed [39:0] gacc_reg;
  reg signed [39:0] gacc_sum;
  reg signed [39:0] gacc_next;
  reg gstep_next;
  reg gdir_next;
  wire dir_pos = dir_lvl ^ dir_inv;
  wire signed [39:0] gear_ext = {{8{gear_reg[31]}}, gear_reg};

  always @* begin
    gacc_sum = gacc_reg;
    if (ext_step && sdin_mode != `RGS_SDIN_OFF)
      gacc_sum = dir_pos ? gacc_reg + gear_ext
                         : gacc_reg - gear_ext;
    gstep_next = 1'b0;
    gdir_next = INT_DIR;
    gacc_next = gacc_sum;
    if (gacc_sum >= `RGS_GEAR_ONE) begin
      gstep_next = 1'b1;
      gdir_next = 1'b1;
      gacc_next = gacc_sum - `RGS_GEAR_ONE;
    end else if (gacc_sum <= -`RGS_GEAR_ONE) begin
      gstep_next = 1'b1;
      gdir_next = 1'b0;
      gacc_next = gacc_sum + `RGS_GEAR_ONE;
    end
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      gacc_reg <= 40'sh00_0000_0000;
      INT_STEP <= 1'b0;
      INT_DIR <= 1'b1;
      INT_GEN_EN <= 1'b1;
      position_reg <= 32'h0000_0000;
    end else begin
      gacc_reg <= gacc_next;
      INT_STEP <= gstep_next;
      INT_DIR <= gdir_next;
      INT_GEN_EN <= (sdin_mode == `RGS_SDIN_OFF);
      if (gstep_next)
        position_reg <= gdir_next ? position_reg + 32'h0000_0001
                                  : position_reg - 32'h0000_0001;
    end
  end

endmodule // rgs_ramp_units

/* rtl/rgs_step_sync.v */
// step and direction input synchroniser with step edge selection
// assumes pins are asynchronous to CLK_SYS
`timescale 1ns/1ps
module rgs_step_sync (
  input wire clk,
  input wire rst_n,
  input wire step_pin,
  input wire dir_pin,
  input wire [1:0] mode,
  output reg step_evt,
  output reg dir_level
);
`include "rgs_consts.vh"

  // ****************************************
  // three stage synchronisers
  // ****************************************
  reg [2:0] step_sh_reg;
  reg [2:0] dir_sh_reg;
  reg step_lvl_reg;
  reg step_next;

  always @(posedge clk) begin
    if (!rst_n) begin
      step_sh_reg <= 3'h0;
      dir_sh_reg <= 3'h0;
    end else begin
      step_sh_reg <= {step_sh_reg[1:0], step_pin};
      dir_sh_reg <= {dir_sh_reg[1:0], dir_pin};
    end
  end

  // ****************************************
  // level filter and edge select
  // ****************************************
  always @* begin
    step_next = 1'b0;
    if (step_sh_reg[1] == step_sh_reg[2] &&
        step_sh_reg[2] != step_lvl_reg) begin
      case (mode)
        `RGS_SDIN_RISE: step_next = step_sh_reg[2];
        `RGS_SDIN_FALL: step_next = ~step_sh_reg[2];
        `RGS_SDIN_BOTH: step_next = 1'b1;
        default: step_next = 1'b0;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      step_lvl_reg <= 1'b0;
      dir_level <= 1'b0;
      step_evt <= 1'b0;
    end else begin
      if (step_sh_reg[1] == step_sh_reg[2])
        step_lvl_reg <= step_sh_reg[2];
      if (dir_sh_reg[1] == dir_sh_reg[2])
        dir_level <= dir_sh_reg[2];
      step_evt <= step_next;
    end
  end

endmodule // rgs_step_sync

/* test/rgs_ramp_units_monitor.sv */
// checker for the ramp units block, step input side
// sees only the top ports; bound at the foot of this file
`timescale 1ns/1ps
`include "rgs_consts.vh"
module rgs_ramp_units_monitor (
  input wire CLK_SYS,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  input wire STEP_IN,
  input wire DIR_IN,
  input wire INT_STEP,
  input wire INT_DIR,
  input wire INT_GEN_EN
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ************************************
  // shadow of mode, invert and gearing
  // ************************************
  reg [1:0] mode_reg;
  reg inv_reg;
  reg one_reg;
  reg neg_reg;
  wire wr_en = PSEL && PENABLE && PWRITE && PREADY;
  wire gc_wr = wr_en && (PADDR[11:2] == `RGS_IDX_GCONF);
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mode_reg <= `RGS_SDIN_OFF;
      inv_reg <= 1'b0;
      one_reg <= 1'b1;
      neg_reg <= 1'b0;
    end else if (gc_wr) begin
      mode_reg <= PWDATA[7:6];
      inv_reg <= PWDATA[8];
    end else if (wr_en && PADDR[11:2] == `RGS_IDX_GEAR) begin
      one_reg <= (PWDATA == `RGS_GEAR_RST);
      neg_reg <= PWDATA[31];
    end
  end
  // ************************************
  // properties
  // ************************************
  sequence s_rise;
    mode_reg == `RGS_SDIN_RISE && one_reg && $rose(STEP_IN);
  endsequence
  sequence s_fall;
    mode_reg == `RGS_SDIN_FALL && one_reg && $fell(STEP_IN);
  endsequence
  sequence s_both;
    mode_reg == `RGS_SDIN_BOTH && one_reg && $changed(STEP_IN);
  endsequence
  sequence s_out;
    ##[3:7] INT_STEP;
  endsequence
  property p_rise; s_rise |-> s_out; endproperty
  property p_fall; s_fall |-> s_out; endproperty
  property p_both; s_both |-> s_out; endproperty
  property p_no_fall;
    mode_reg == `RGS_SDIN_RISE && one_reg && $fell(STEP_IN)
      |-> ##2 !INT_STEP [*4];
  endproperty
  property p_gen_off;
    gc_wr && PWDATA[7:6] != 2'h0 |-> ##[1:3] !INT_GEN_EN;
  endproperty
  property p_quiet; INT_STEP |-> !INT_GEN_EN; endproperty
  property p_single; one_reg && INT_STEP |=> !INT_STEP; endproperty
  property p_dir;
    INT_STEP && !neg_reg |-> INT_DIR == (DIR_IN ^ inv_reg);
  endproperty
  a_rise: assert property (p_rise) else $error("no step on rise");
  a_fall: assert property (p_fall) else $error("no step on fall");
  a_both: assert property (p_both) else $error("no step on edge");
  a_no_fall: assert property (p_no_fall) else $error("fall stepped");
  a_gen_off: assert property (p_gen_off) else $error("gen on");
  a_quiet: assert property (p_quiet) else $error("step in gen mode");
  a_single: assert property (p_single) else $error("double step");
  a_dir: assert property (p_dir) else $error("bad direction");
endmodule // rgs_ramp_units_monitor

bind rgs_ramp_units rgs_ramp_units_monitor u_mon (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .STEP_IN(STEP_IN),
  .DIR_IN(DIR_IN), .INT_STEP(INT_STEP), .INT_DIR(INT_DIR),
  .INT_GEN_EN(INT_GEN_EN));

/* test/rgs_ramp_units_test.sv */
// self-checking bench for the ramp units block
// apb master here, step host partner, monitor bound to the top
`timescale 1ns/1ps
`include "rgs_consts.vh"
module rgs_ramp_units_test;
  reg CLK_SYS = 1'b0;
  reg RST_N = 1'b0;
  reg PSEL = 1'b0;
  reg PENABLE = 1'b0;
  reg PWRITE = 1'b0;
  reg [11:0] PADDR = 12'h000;
  reg [31:0] PWDATA = 32'h0000_0000;
  wire [31:0] PRDATA;
  wire [31:0] PRESENT_ACCEL;
  wire PREADY, PSLVERR, STEP_IN, DIR_IN, INT_STEP, INT_DIR, INT_GEN_EN;
  int failures = 0;
  int num_checks = 0;
  int i, n;
  logic [32:0] exp_q[$];
  logic [31:0] steps = 32'h0;
  logic [31:0] exp_pos = 32'h0;
  logic [31:0] b, e, v;
  real ea;
  logic [1:0] tm[6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h0};
  bit ti[6] = '{0, 0, 1, 0, 0, 0};
  bit td[6] = '{1, 0, 0, 1, 1, 1};
  logic [31:0] tg[6] = '{32'h0100_0000, 32'h0100_0000, 32'h0100_0000,
    32'h0080_0000, 32'hff00_0000, 32'h0100_0000};
  rgs_ramp_units DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STEP_IN(STEP_IN), .DIR_IN(DIR_IN), .INT_STEP(INT_STEP),
    .INT_DIR(INT_DIR), .INT_GEN_EN(INT_GEN_EN),
    .PRESENT_ACCEL(PRESENT_ACCEL));
  rgs_step_host SRC (.clk(CLK_SYS), .step(STEP_IN), .dir(DIR_IN));
  initial forever #10 CLK_SYS = ~CLK_SYS;
  // ************************************
  // checking and apb tasks
  // ************************************
  task automatic check(input string nm, input logic [32:0] s, x);
    begin
      num_checks++;
      if (s !== x) begin
        failures++;
        $display("mismatch %s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task automatic print_verdict;
    begin
      if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task automatic xfer(input bit w, input [9:0] ix, input [31:0] d);
    int k;
    begin
      k = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {ix, 2'b00};
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      @(posedge CLK_SYS);
      while (PREADY !== 1'b1 && k < 50) begin
        k++;
        @(posedge CLK_SYS);
      end
      if (k == 50) begin
        failures++;
        print_verdict();
      end
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK_SYS);
    end
  endtask
  task automatic rd(input [9:0] ix, input [32:0] x);
    begin
      exp_q.push_back(x);
      xfer(1'b0, ix, 32'h0);
    end
  endtask
  // read data and step pulses watched here
  always @(posedge CLK_SYS) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && exp_q.size() > 0)
      check("prdata", {PSLVERR, PRDATA}, exp_q.pop_front());
    if (INT_STEP === 1'b1) steps <= steps + 32'h1;
  end
  initial begin
    repeat (100000) @(posedge CLK_SYS);
    failures++;
    print_verdict();
  end
  // ************************************
  // main sequence
  // ************************************
  initial begin
    void'($urandom(32'habe8abea));
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    rd(`RGS_IDX_GCONF, {1'b0, `RGS_GCONF_RST});
    rd(`RGS_IDX_GEAR, {1'b0, `RGS_GEAR_RST});
    rd(10'h3ff, {1'b1, 32'h0});
    v = $urandom_range(32'h10_0000);
    xfer(1'b1, `RGS_IDX_JERK_1, v | 32'hff00_0000);
    rd(`RGS_IDX_JERK_1, {1'b0, v});
    xfer(1'b1, `RGS_IDX_MAX_ACCEL, v | 32'hff00_0000);
    rd(`RGS_IDX_MAX_ACCEL, {1'b0, v});
    xfer(1'b1, `RGS_IDX_PRESENT_ACCEL, v);
    rd(`RGS_IDX_PRESENT_ACCEL, 33'h0);
    ea = 16.0 * `RGS_CLK_HZ * 1.0 * `RGS_CLK_HZ / (2.0 ** 37);
    xfer(1'b1, `RGS_IDX_GCONF, 32'h0000_0006);
    xfer(1'b1, `RGS_IDX_MAX_ACCEL, 32'h0000_0010);
    xfer(1'b1, `RGS_IDX_MAX_DECEL, 32'h0000_0010);
    xfer(1'b1, `RGS_IDX_JERK_1, 32'h0010_0000);
    xfer(1'b1, `RGS_IDX_JERK_4 - 10'h001, 32'h0010_0000);
    xfer(1'b1, `RGS_IDX_RAMP_CTRL, 32'h0000_0001);
    repeat (4) @(posedge CLK_SYS);
    xfer(1'b0, `RGS_IDX_PRESENT_ACCEL, 32'h0);
    check("accel_run", ($signed(PRDATA) > ea - 64.0 &&
      $signed(PRDATA) < ea + 64.0), 1'b1);
    xfer(1'b1, `RGS_IDX_RAMP_CTRL, 32'h0000_0002);
    repeat (4) @(posedge CLK_SYS);
    xfer(1'b0, `RGS_IDX_PRESENT_ACCEL, 32'h0);
    check("accel_brake", ($signed(PRDATA) < 64.0 - ea &&
      $signed(PRDATA) > -64.0 - ea), 1'b1);
    xfer(1'b1, `RGS_IDX_GEAR, 32'h8000_0001);
    rd(`RGS_IDX_GEAR, {1'b0, 32'h8000_0001});
    for (i = 0; i < 6; i++) begin
      n = (i == 3) ? 4 : $urandom_range(5, 2);
      e = (tm[i] == 2'h3) ? 2 * n : (tm[i] == 2'h0) ? 0 : n;
      if (i == 3) e = n / 2;
      xfer(1'b1, `RGS_IDX_GCONF, {23'h0, ti[i], tm[i], 6'h0});
      xfer(1'b1, `RGS_IDX_GEAR, tg[i]);
      repeat (4) @(posedge CLK_SYS);
      check("gen_en", INT_GEN_EN, tm[i] == 2'h0);
      b = steps;
      SRC.pulses(n, td[i]);
      repeat (12) @(posedge CLK_SYS);
      check("steps", steps - b, e);
      if (td[i] ^ ti[i] ^ tg[i][31]) exp_pos = exp_pos + e;
      else exp_pos = exp_pos - e;
      rd(`RGS_IDX_POSITION, {1'b0, exp_pos});
    end
    print_verdict();
  end
endmodule // rgs_ramp_units_test

/* test/rgs_step_host.sv */
// step and direction source standing in for another controller
// drives pins just after rising edges; step idles low
`timescale 1ns/1ps
module rgs_step_host (
  input wire clk,
  output reg step,
  output reg dir
);
  initial begin
    step = 1'b0;
    dir = 1'b1;
  end
  // pulses of 4 to 7 cycles per level
  task automatic pulses(input int n, input bit d);
    int i;
    begin
      dir <= d;
      repeat (4) @(posedge clk);
      for (i = 0; i < n; i++) begin
        step <= 1'b1;
        repeat ($urandom_range(7, 4)) @(posedge clk);
        step <= 1'b0;
        repeat ($urandom_range(7, 4)) @(posedge clk);
      end
    end
  endtask
endmodule // rgs_step_host
